// ---- epr_pkg.sv ----
package epr_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_FREQ_KHZ = 50000;
    localparam int unsigned PROG_TIME_US = 10000;
    localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_FREQ_KHZ / 1000;

    // ****************************************
    // Serial link
    // ****************************************
    localparam logic [6:0] DEV_ADDR = 7'h2A;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TX_LAST_BIT = 4'h7;
    localparam logic [1:0] BYTE_DEV = 2'h0;
    localparam logic [1:0] BYTE_REG = 2'h1;
    localparam logic [1:0] BYTE_HI = 2'h2;
    localparam logic [1:0] BYTE_LO = 2'h3;

    // ****************************************
    // Register numbers
    // ****************************************
    localparam logic [7:0] REG_ROTOR_SPEED = 8'h78;
    localparam logic [7:0] REG_BUS_CURRENT = 8'h79;
    localparam logic [7:0] REG_TORQUE_CURRENT = 8'h7A;
    localparam logic [7:0] REG_SUPPLY_VOLTAGE = 8'h7B;
    localparam logic [7:0] REG_DIE_TEMPERATURE = 8'h7C;
    localparam logic [7:0] REG_SPEED_DEMAND = 8'h7D;
    localparam logic [7:0] REG_SPEED_COMMAND = 8'h7E;
    localparam logic [7:0] REG_STORE_CONTROL = 8'hA1;
    localparam logic [7:0] REG_STORE_ADDRESS = 8'hA2;
    localparam logic [7:0] REG_STORE_DATA = 8'hA3;

    // ****************************************
    // Store layout and fields
    // ****************************************
    localparam int unsigned NVM_WORDS = 24;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned IDX_W = 5;
    localparam logic [7:0] NVM_LAST_REG = 8'h17;
    localparam int unsigned HV_ON_BIT = 0;
    localparam int unsigned WIPE_MODE_BIT = 1;
    localparam int unsigned PROGRAM_MODE_BIT = 2;
    localparam int unsigned FETCH_MODE_BIT = 3;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [15:0] ERASED_WORD = 16'h0000;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_RACK = 5'h10
    } epr_link_state_t;

endpackage

// ---- epr_nvm_store.sv ----
`timescale 1ns/1ps
module epr_nvm_store #(
    parameter int unsigned PROG_TICKS = epr_pkg::PROG_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic wipe_i,
    input wire logic [epr_pkg::IDX_W-1:0] index_i,
    input wire logic [epr_pkg::WORD_W-1:0] data_i,
    input wire logic [epr_pkg::IDX_W-1:0] rd_index_i,
    output logic [epr_pkg::WORD_W-1:0] rd_word_o,
    output logic busy_o
);
    import epr_pkg::*;

    logic [WORD_W-1:0] mem_reg [NVM_WORDS];
    logic [31:0] tick_reg;
    logic busy_reg;
    logic wipe_reg;
    logic [IDX_W-1:0] idx_reg;
    logic [WORD_W-1:0] data_reg;
    logic done;

    assign done = busy_reg && (tick_reg == PROG_TICKS - 32'd1);
    assign busy_o = busy_reg;
    assign rd_word_o = (32'(rd_index_i) < NVM_WORDS) ? mem_reg[rd_index_i] : 16'h0000;

    // ****************************************
    // Programming interval
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            busy_reg <= 1'b0;
            tick_reg <= 32'h0;
            wipe_reg <= 1'b0;
            idx_reg <= '0;
            data_reg <= '0;
        end else if (ce_i) begin
            if (!busy_reg && start_i && 32'(index_i) < NVM_WORDS) begin
                busy_reg <= 1'b1;
                tick_reg <= 32'h0;
                wipe_reg <= wipe_i;
                idx_reg <= index_i;
                data_reg <= data_i;
            end else if (done) begin
                busy_reg <= 1'b0;
            end else if (busy_reg) begin
                tick_reg <= tick_reg + 32'd1;
            end
        end
    end

    // ****************************************
    // Word array
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < NVM_WORDS; i++) begin
                mem_reg[i] <= ERASED_WORD;
            end
        end else if (ce_i && done) begin
            if (wipe_reg) begin
                mem_reg[idx_reg] <= ERASED_WORD;
            end else begin
                // Write only adds bits; an erase must come first
                mem_reg[idx_reg] <= mem_reg[idx_reg] | data_reg;
            end
        end
    end

endmodule

// ---- epr_top.sv ----
`timescale 1ns/1ps
module epr_top #(
    parameter int unsigned PROG_TICKS = epr_pkg::PROG_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [epr_pkg::WORD_W-1:0] rotor_speed_i,
    input wire logic [epr_pkg::WORD_W-1:0] bus_current_i,
    input wire logic [epr_pkg::WORD_W-1:0] torque_current_i,
    input wire logic [epr_pkg::WORD_W-1:0] supply_level_i,
    input wire logic [epr_pkg::WORD_W-1:0] die_temperature_i,
    input wire logic [epr_pkg::WORD_W-1:0] speed_demand_i,
    input wire logic [epr_pkg::WORD_W-1:0] speed_command_i,
    output logic nvm_busy_o
);
    import epr_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    epr_link_state_t state_reg;
    logic scl_q_reg;
    logic sda_q_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic [1:0] byte_idx_reg;
    logic reading_reg;
    logic [7:0] reg_ptr_reg;
    logic [7:0] wr_hi_reg;
    logic [WORD_W-1:0] tx_word_reg;
    logic [7:0] tx_shift_reg;
    logic tx_hi_sent_reg;
    logic master_nack_reg;
    logic sda_oe_reg;
    logic wr_pulse_reg;
    logic [WORD_W-1:0] wr_word_reg;
    logic [WORD_W-1:0] store_operation_control_reg;
    logic [WORD_W-1:0] store_word_address_reg;
    logic [WORD_W-1:0] store_new_data_reg;
    logic launch_reg;
    logic busy_q_reg;
    logic store_busy;
    logic [WORD_W-1:0] store_rd_word;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [WORD_W-1:0] rd_value;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic launch_ok(input logic [WORD_W-1:0] ctrl);
        launch_ok = ctrl[HV_ON_BIT] && (ctrl[WIPE_MODE_BIT] ^ ctrl[PROGRAM_MODE_BIT]);
    endfunction

    function automatic logic [WORD_W-1:0] read_mux(input logic [7:0] num);
        if (num <= NVM_LAST_REG) begin
            read_mux = store_rd_word;
        end else begin
            case (num)
                REG_ROTOR_SPEED: read_mux = rotor_speed_i;
                REG_BUS_CURRENT: read_mux = bus_current_i;
                REG_TORQUE_CURRENT: read_mux = torque_current_i;
                REG_SUPPLY_VOLTAGE: read_mux = supply_level_i;
                REG_DIE_TEMPERATURE: read_mux = die_temperature_i;
                REG_SPEED_DEMAND: read_mux = speed_demand_i;
                REG_SPEED_COMMAND: read_mux = speed_command_i;
                REG_STORE_CONTROL: read_mux = store_operation_control_reg;
                REG_STORE_ADDRESS: read_mux = store_word_address_reg;
                REG_STORE_DATA: read_mux = store_new_data_reg;
                default: read_mux = 16'h0000;
            endcase
        end
    endfunction

    assign scl_rise = scl_i && !scl_q_reg;
    assign scl_fall = !scl_i && scl_q_reg;
    assign start_cond = scl_i && scl_q_reg && sda_q_reg && !sda_i;
    assign stop_cond = scl_i && scl_q_reg && !sda_q_reg && sda_i;
    assign rd_value = read_mux(reg_ptr_reg);

    assign sda_oe_o = sda_oe_reg;
    assign nvm_busy_o = busy_q_reg;

    // ****************************************
    // Line sampling
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
            sda_o <= 1'b0;
            busy_q_reg <= 1'b0;
        end else if (ce_i) begin
            scl_q_reg <= scl_i;
            sda_q_reg <= sda_i;
            sda_o <= 1'b0;
            busy_q_reg <= store_busy;
        end
    end

    // ****************************************
    // Serial slave
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            byte_idx_reg <= BYTE_DEV;
            reading_reg <= 1'b0;
            reg_ptr_reg <= 8'h00;
            wr_hi_reg <= 8'h00;
            tx_word_reg <= 16'h0000;
            tx_shift_reg <= 8'h00;
            tx_hi_sent_reg <= 1'b0;
            master_nack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            wr_pulse_reg <= 1'b0;
            wr_word_reg <= 16'h0000;
        end else if (ce_i) begin
            wr_pulse_reg <= 1'b0;
            if (start_cond) begin
                state_reg <= ST_RX;
                bit_cnt_reg <= 4'h0;
                byte_idx_reg <= BYTE_DEV;
                sda_oe_reg <= 1'b0;
            end else if (stop_cond) begin
                state_reg <= ST_IDLE;
                sda_oe_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        sda_oe_reg <= 1'b0;
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_i};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
                            bit_cnt_reg <= 4'h0;
                            state_reg <= ST_ACK;
                            sda_oe_reg <= 1'b1;
                            case (byte_idx_reg)
                                BYTE_DEV: begin
                                    // Busy store: stay off the link
                                    if (shift_reg[7:1] != DEV_ADDR || store_busy) begin
                                        state_reg <= ST_IDLE;
                                        sda_oe_reg <= 1'b0;
                                    end
                                    reading_reg <= shift_reg[0];
                                    tx_word_reg <= rd_value;
                                    byte_idx_reg <= BYTE_REG;
                                end
                                BYTE_REG: begin
                                    reg_ptr_reg <= shift_reg;
                                    byte_idx_reg <= BYTE_HI;
                                end
                                BYTE_HI: begin
                                    wr_hi_reg <= shift_reg;
                                    byte_idx_reg <= BYTE_LO;
                                end
                                BYTE_LO: begin
                                    wr_word_reg <= {wr_hi_reg, shift_reg};
                                    wr_pulse_reg <= 1'b1;
                                    byte_idx_reg <= BYTE_HI;
                                end
                                default: begin
                                    byte_idx_reg <= BYTE_DEV;
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (reading_reg) begin
                                state_reg <= ST_TX;
                                tx_shift_reg <= tx_word_reg[15:8];
                                tx_hi_sent_reg <= 1'b1;
                                sda_oe_reg <= !tx_word_reg[15];
                            end else begin
                                state_reg <= ST_RX;
                                sda_oe_reg <= 1'b0;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == TX_LAST_BIT) begin
                                bit_cnt_reg <= 4'h0;
                                state_reg <= ST_RACK;
                                sda_oe_reg <= 1'b0;
                            end else begin
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                                sda_oe_reg <= !tx_shift_reg[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            master_nack_reg <= sda_i;
                        end else if (scl_fall) begin
                            if (master_nack_reg) begin
                                state_reg <= ST_IDLE;
                                sda_oe_reg <= 1'b0;
                            end else if (tx_hi_sent_reg) begin
                                state_reg <= ST_TX;
                                tx_shift_reg <= tx_word_reg[7:0];
                                tx_hi_sent_reg <= 1'b0;
                                sda_oe_reg <= !tx_word_reg[7];
                            end else begin
                                // Further reads repeat the same register
                                state_reg <= ST_TX;
                                tx_word_reg <= rd_value;
                                tx_shift_reg <= rd_value[15:8];
                                tx_hi_sent_reg <= 1'b1;
                                sda_oe_reg <= !rd_value[15];
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        sda_oe_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Store registers
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            store_operation_control_reg <= CTRL_RESET;
            store_word_address_reg <= ADDR_RESET;
            store_new_data_reg <= DATA_RESET;
            launch_reg <= 1'b0;
        end else if (ce_i) begin
            launch_reg <= 1'b0;
            if (wr_pulse_reg) begin
                case (reg_ptr_reg)
                    REG_STORE_CONTROL: begin
                        store_operation_control_reg <= wr_word_reg;
                        launch_reg <= launch_ok(wr_word_reg) && !store_busy;
                    end
                    REG_STORE_ADDRESS: begin
                        store_word_address_reg <= wr_word_reg;
                    end
                    REG_STORE_DATA: begin
                        store_new_data_reg <= wr_word_reg;
                    end
                    default: begin
                        launch_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Parameter store
    // ****************************************
    epr_nvm_store #(
        .PROG_TICKS(PROG_TICKS)
    ) u_store (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .start_i(launch_reg),
        .wipe_i(store_operation_control_reg[WIPE_MODE_BIT]),
        .index_i(store_word_address_reg[IDX_W-1:0]),
        .data_i(store_new_data_reg),
        .rd_index_i(reg_ptr_reg[IDX_W-1:0]),
        .rd_word_o(store_rd_word),
        .busy_o(store_busy)
    );

endmodule

// ---- epr_chk.sv ----
`timescale 1ns/1ps
module epr_chk #(
    parameter int unsigned PROG_TICKS = 400
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic nvm_busy_o
);
    logic [31:0] busy_cnt;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            busy_cnt <= 32'h0;
        end else if (ce_i) begin
            busy_cnt <= nvm_busy_o ? busy_cnt + 32'h1 : 32'h0;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    chk_sda_drive_low: assert property (sda_o == 1'b0)
        else $error("data out not low");
    chk_reset_quiet: assert property (disable iff (1'b0) !resetn_i |=> !sda_oe_o && !nvm_busy_o)
        else $error("outputs active after reset");
    chk_oe_scl_high: assert property (scl_i |-> $stable(sda_oe_o))
        else $error("data line moved while clock high");
    chk_oe_hold: assert property ($rose(sda_oe_o) |-> sda_oe_o [*3])
        else $error("data pull too short");
    chk_start_free: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> !sda_oe_o)
        else $error("device pulled line at start");
    chk_busy_max: assert property (busy_cnt <= PROG_TICKS)
        else $error("busy too long");
    chk_busy_exact: assert property ($fell(nvm_busy_o) |-> busy_cnt == PROG_TICKS)
        else $error("busy length wrong");
    chk_busy_no_ack: assert property (nvm_busy_o && $past(nvm_busy_o, 20) |-> !$rose(sda_oe_o))
        else $error("ack while busy");
endmodule

bind epr_top epr_chk #(.PROG_TICKS(PROG_TICKS)) i_chk (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .nvm_busy_o(nvm_busy_o)
);

// ---- epr_host_model.sv ----
`timescale 1ns/1ps
module epr_host_model #(
    parameter int unsigned WAIT_TICKS = 600
) (
    input wire logic clk_sys_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    import epr_pkg::*;

    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic half();
        repeat (4) @(posedge clk_sys_i);
    endtask

    task automatic start();
        sda_low_o <= 1'b0;
        half();
        scl_o <= 1'b1;
        half();
        sda_low_o <= 1'b1;
        half();
        scl_o <= 1'b0;
        half();
    endtask

    task automatic stop();
        sda_low_o <= 1'b1;
        half();
        scl_o <= 1'b1;
        half();
        sda_low_o <= 1'b0;
        half();
    endtask

    task automatic xfer_bit(input logic b, output logic r);
        sda_low_o <= ~b;
        half();
        scl_o <= 1'b1;
        half();
        r = sda_i;
        scl_o <= 1'b0;
        half();
    endtask

    task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(tx[i], rx[i]);
        end
    endtask

    task automatic wbyte(input logic [7:0] tx, output logic ack);
        logic [7:0] rx;
        logic r;
        xfer_byte(tx, rx);
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask

    task automatic wr_reg(input logic [7:0] num, input logic [15:0] val, output logic ok);
        logic [3:0] a;
        start();
        wbyte({DEV_ADDR, 1'b0}, a[0]);
        wbyte(num, a[1]);
        wbyte(val[15:8], a[2]);
        wbyte(val[7:0], a[3]);
        stop();
        ok = &a;
    endtask

    task automatic rd_reg(input logic [7:0] num, output logic [15:0] val, output logic ok);
        logic [2:0] a;
        logic r;
        start();
        wbyte({DEV_ADDR, 1'b0}, a[0]);
        wbyte(num, a[1]);
        start();
        wbyte({DEV_ADDR, 1'b1}, a[2]);
        xfer_byte(8'hFF, val[15:8]);
        xfer_bit(1'b0, r);
        xfer_byte(8'hFF, val[7:0]);
        xfer_bit(1'b1, r);
        stop();
        ok = &a;
    endtask

    task automatic program_word(input logic [4:0] idx, input logic [15:0] val, input logic wipe, output logic ok);
        logic [2:0] a;
        wr_reg(REG_STORE_ADDRESS, {11'h000, idx}, a[0]);
        wr_reg(REG_STORE_DATA, wipe ? 16'h0000 : val, a[1]);
        wr_reg(REG_STORE_CONTROL, wipe ? 16'h0003 : 16'h0005, a[2]);
        ok = &a;
    endtask

    task automatic settle();
        repeat (WAIT_TICKS) @(posedge clk_sys_i);
    endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import epr_pkg::*;
    localparam int unsigned TICKS = 400;
    typedef struct {
        logic [7:0] num;
        logic [15:0] exp;
    } epr_row_t;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic scl;
    logic sda_low;
    logic sda_line;
    logic sda_o;
    logic sda_oe_o;
    logic nvm_busy_o;
    logic ok;
    logic [15:0] tel [0:6] = '{16'h1234, 16'h0A5B, 16'h00C3, 16'h00FF, 16'h0049, 16'h01FF, 16'h0100};
    logic [15:0] ctl [0:5] = '{16'h0002, 16'h0004, 16'h0006, 16'h0007, 16'h0001, 16'h0008};
    epr_row_t rows [0:11];
    int failures = 0;
    int n_checks = 0;

    assign sda_line = ~(sda_low | sda_oe_o);
    always #10 clk_sys_i = ~clk_sys_i;

    epr_top #(.PROG_TICKS(TICKS)) i_dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .rotor_speed_i(tel[0]), .bus_current_i(tel[1]), .torque_current_i(tel[2]),
        .supply_level_i(tel[3]), .die_temperature_i(tel[4]), .speed_demand_i(tel[5]),
        .speed_command_i(tel[6]), .nvm_busy_o(nvm_busy_o)
    );

    epr_host_model #(.WAIT_TICKS(TICKS * 3 / 2)) i_host (
        .clk_sys_i(clk_sys_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low)
    );

    task automatic results();
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic read_chk(input logic [7:0] num, input logic [15:0] exp);
        logic a;
        logic [15:0] v;
        i_host.rd_reg(num, v, a);
        cmp_bit("read ack", 1'b1, a);
        cmp_word($sformatf("reg %h", num), exp, v);
    endtask

    task automatic do_reset();
        resetn_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys_i);
        failures++;
        results();
    end

    initial begin
        rows = '{'{REG_ROTOR_SPEED, tel[0]}, '{REG_BUS_CURRENT, tel[1]}, '{REG_TORQUE_CURRENT, tel[2]},
                 '{REG_SUPPLY_VOLTAGE, tel[3]}, '{REG_DIE_TEMPERATURE, tel[4]}, '{REG_SPEED_DEMAND, tel[5]},
                 '{REG_SPEED_COMMAND, tel[6]}, '{REG_STORE_CONTROL, 16'h0000}, '{REG_STORE_ADDRESS, 16'h0000},
                 '{REG_STORE_DATA, 16'h0000}, '{8'h17, 16'h0000}, '{8'h50, 16'h0000}};
        do_reset();
        foreach (rows[i]) read_chk(rows[i].num, rows[i].exp);
        i_host.program_word(5'h07, 16'h0000, 1'b1, ok);
        cmp_bit("erase ack", 1'b1, ok);
        i_host.settle();
        i_host.program_word(5'h07, 16'h0105, 1'b0, ok);
        cmp_bit("launch ack", 1'b1, ok);
        cmp_bit("busy", 1'b1, nvm_busy_o);
        i_host.wr_reg(REG_STORE_DATA, 16'h0000, ok);
        cmp_bit("busy refusal", 1'b0, ok);
        i_host.settle();
        cmp_bit("busy end", 1'b0, nvm_busy_o);
        read_chk(8'h07, 16'h0105);
        read_chk(8'h08, 16'h0000);
        read_chk(REG_STORE_CONTROL, 16'h0005);
        i_host.program_word(5'h07, 16'h00F0, 1'b0, ok);
        i_host.settle();
        read_chk(8'h07, 16'h01F5);
        i_host.program_word(5'h07, 16'h0000, 1'b1, ok);
        i_host.settle();
        read_chk(8'h07, 16'h0000);
        i_host.program_word(5'h17, 16'hFFFF, 1'b0, ok);
        i_host.settle();
        read_chk(8'h17, 16'hFFFF);
        read_chk(REG_STORE_DATA, 16'hFFFF);
        foreach (ctl[i]) begin
            i_host.wr_reg(REG_STORE_CONTROL, ctl[i], ok);
            repeat (4) @(posedge clk_sys_i);
            cmp_bit("no launch", 1'b0, nvm_busy_o);
            read_chk(REG_STORE_CONTROL, ctl[i]);
        end
        // Clock enable low must stretch the programming interval
        i_host.program_word(5'h09, 16'h00A5, 1'b0, ok);
        ce_i <= 1'b0;
        repeat (TICKS + 100) @(posedge clk_sys_i);
        cmp_bit("busy frozen", 1'b1, nvm_busy_o);
        ce_i <= 1'b1;
        i_host.settle();
        cmp_bit("busy end after freeze", 1'b0, nvm_busy_o);
        read_chk(8'h09, 16'h00A5);
        // Reset in mid-operation
        i_host.program_word(5'h17, 16'h0001, 1'b0, ok);
        do_reset();
        cmp_bit("busy after reset", 1'b0, nvm_busy_o);
        read_chk(8'h17, 16'h0000);
        read_chk(REG_STORE_ADDRESS, 16'h0000);
        results();
    end
endmodule
